// >>> dbsm_pkg.sv
// Constants and types for the dynamic bus sizing data multiplexer and cycle sequencer.
package dbsm_pkg;

  localparam logic [1:0] DBSM_SIZE_BYTE  = 2'h1;
  localparam logic [1:0] DBSM_SIZE_WORD  = 2'h2;
  localparam logic [1:0] DBSM_SIZE_THREE = 2'h3;
  localparam logic [1:0] DBSM_SIZE_LONG  = 2'h0;
  localparam int         DBSM_ADDR_W     = 32;
  localparam int         DBSM_DATA_W     = 32;

  typedef enum logic [2:0] {
    DBSM_IDLE = 3'h1,
    DBSM_BUSY = 3'h2,
    DBSM_DONE = 3'h4
  } dbsm_state_e;

  // Bytes still to move for a size code; long word is encoded as zero.
  function automatic logic [2:0] dbsm_count(input logic [1:0] size);
    dbsm_count = (size == DBSM_SIZE_LONG) ? 3'h4 : {1'b0, size};
  endfunction : dbsm_count

  // Bytes a port of the acknowledged width can take in this cycle.
  function automatic logic [2:0] dbsm_moved(input logic [1:0] size, input logic [1:0] offs,
                                            input logic ack_hi, input logic ack_lo);
    logic [2:0] room;
    logic [2:0] left;
    left = dbsm_count(size);
    if (ack_hi && ack_lo) begin
      room = 3'h4 - {1'b0, offs};
    end else if (ack_hi) begin
      room = offs[0] ? 3'h1 : 3'h2;
    end else begin
      room = 3'h1;
    end
    dbsm_moved = (room < left) ? room : left;
  endfunction : dbsm_moved

endpackage : dbsm_pkg

// >>> dbsm_write_mux.sv
// Write-data lane steering from size code and byte offset.
`timescale 1ns/10ps
module dbsm_write_mux
  import dbsm_pkg::*;
(
  input  wire logic [1:0]  size_in,
  input  wire logic [1:0]  offs_in,
  input  wire logic [31:0] opnd_in,
  output logic      [31:0] lanes_out
);
  logic [7:0] opnd_byte_msb;
  logic [7:0] opnd_byte_second;
  logic [7:0] opnd_byte_third;
  logic [7:0] opnd_byte_lsb;

  assign opnd_byte_msb    = opnd_in[31:24];
  assign opnd_byte_second = opnd_in[23:16];
  assign opnd_byte_third  = opnd_in[15:8];
  assign opnd_byte_lsb    = opnd_in[7:0];

  // Filler lanes repeat a real byte so that the bus is never left floating.
  always_comb begin
    unique case (size_in)
      DBSM_SIZE_BYTE: lanes_out = {4{opnd_byte_lsb}};
      DBSM_SIZE_WORD: begin
        if (offs_in[0]) begin
          lanes_out = {opnd_byte_third, opnd_byte_third, opnd_byte_lsb, opnd_byte_third};
        end else begin
          lanes_out = {opnd_byte_third, opnd_byte_lsb, opnd_byte_third, opnd_byte_lsb};
        end
      end
      DBSM_SIZE_THREE: begin
        unique case (offs_in)
          2'h0: lanes_out = {opnd_byte_second, opnd_byte_third, opnd_byte_lsb, opnd_byte_msb};
          2'h1: lanes_out = {opnd_byte_second, opnd_byte_second, opnd_byte_third, opnd_byte_lsb};
          2'h2: lanes_out = {opnd_byte_second, opnd_byte_third, opnd_byte_second, opnd_byte_third};
          2'h3: lanes_out = {opnd_byte_second, opnd_byte_second, opnd_byte_third, opnd_byte_second};
        endcase
      end
      DBSM_SIZE_LONG: begin
        unique case (offs_in)
          2'h0: lanes_out = {opnd_byte_msb, opnd_byte_second, opnd_byte_third, opnd_byte_lsb};
          2'h1: lanes_out = {opnd_byte_msb, opnd_byte_msb, opnd_byte_second, opnd_byte_third};
          2'h2: lanes_out = {opnd_byte_msb, opnd_byte_second, opnd_byte_msb, opnd_byte_second};
          2'h3: lanes_out = {opnd_byte_msb, opnd_byte_msb, opnd_byte_second, opnd_byte_msb};
        endcase
      end
    endcase
  end
endmodule : dbsm_write_mux

// >>> dbsm_sequencer.sv
// Dynamic bus sizing cycle sequencer with write steering and read gathering.
`timescale 1ns/10ps
module dbsm_sequencer
  import dbsm_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        srst_in,
  input  wire logic        clk_en_in,
  input  wire logic        req_in,
  input  wire logic        req_write_in,
  input  wire logic        req_fetch_in,
  input  wire logic [1:0]  req_size_in,
  input  wire logic [31:0] req_addr_in,
  input  wire logic [31:0] req_wdata_in,
  input  wire logic        port_ack_hi_in,
  input  wire logic        port_ack_lo_in,
  input  wire logic [31:0] bus_rdata_in,
  output logic             busy_out,
  output logic             cycle_out,
  output logic             write_out,
  output logic [31:0]      addr_out,
  output logic             xfer_size_msb_out,
  output logic             xfer_size_lsb_out,
  output logic [31:0]      bus_wdata_out,
  output logic             done_out,
  output logic [31:0]      rdata_out,
  output logic             addr_err_out
);
  dbsm_state_e state;
  logic [1:0]  size;
  logic [31:0] opnd;
  logic [31:0] next_lanes;
  logic [2:0]  moved;
  logic [2:0]  left;
  logic        acked;

  assign acked = port_ack_hi_in | port_ack_lo_in;  // Both negated means wait.
  assign left  = dbsm_count(size);
  assign moved = dbsm_moved(size, addr_out[1:0], port_ack_hi_in, port_ack_lo_in);

  dbsm_write_mux dbsm_write_mux_inst (
    .size_in   (size),
    .offs_in   (addr_out[1:0]),
    .opnd_in   (opnd),
    .lanes_out (next_lanes)
  );

  assign xfer_size_msb_out = size[1];
  assign xfer_size_lsb_out = size[0];

  // Sequencer: each acknowledge moves what the port could take, then re-issues the rest.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state        <= DBSM_IDLE;
      busy_out     <= 1'b0;
      cycle_out    <= 1'b0;
      write_out    <= 1'b0;
      addr_out     <= '0;
      size         <= DBSM_SIZE_LONG;
      done_out     <= 1'b0;
      addr_err_out <= 1'b0;
    end else if (clk_en_in) begin
      done_out     <= 1'b0;
      addr_err_out <= 1'b0;
      unique case (state)
        DBSM_IDLE: begin
          if (req_in) begin
            if (req_fetch_in && req_addr_in[0]) begin
              addr_err_out <= 1'b1;  // Prefetch at odd address is refused.
            end else begin
              // Data operands of any alignment are accepted and split.
              state     <= DBSM_BUSY;
              busy_out  <= 1'b1;
              cycle_out <= 1'b1;
              write_out <= req_write_in;
              addr_out  <= req_addr_in;
              size      <= req_size_in;
            end
          end
        end
        DBSM_BUSY: begin
          if (acked) begin
            addr_out <= addr_out + {29'h0, moved};
            if (moved == left) begin
              state     <= DBSM_DONE;
              cycle_out <= 1'b0;
            end else begin
              size <= 2'(left - moved);
            end
          end
        end
        DBSM_DONE: begin
          state    <= DBSM_IDLE;
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end
        default: begin
          state     <= DBSM_IDLE;
          busy_out  <= 1'b0;
          cycle_out <= 1'b0;
        end
      endcase
    end
  end

  // The operand is held right-justified; remaining bytes stay in the low part.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      opnd <= '0;
    end else if (clk_en_in && state == DBSM_IDLE && req_in) begin
      opnd <= req_wdata_in;
    end
  end

  // Lanes are registered, so they settle one cycle after a new size or offset; a slave must not acknowledge sooner.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      bus_wdata_out <= '0;
    end else if (clk_en_in) begin
      bus_wdata_out <= next_lanes;
    end
  end

  // Read gathering: the slave puts the first remaining byte on the offset lane of its port.
  logic [31:0] next_rdata;
  logic [31:0] rsh;
  always_comb begin
    // The first byte sits below the top lane by its offset within the port, so it is lifted to the top.
    rsh        = bus_rdata_in << {3'h0 , (port_ack_hi_in && port_ack_lo_in) ? addr_out[1:0] :
                                  (port_ack_hi_in ? {1'b0, addr_out[0]} : 2'h0), 3'h0};
    next_rdata = rdata_out;
    unique case (moved)
      3'h1: next_rdata = {rdata_out[23:0], rsh[31:24]};
      3'h2: next_rdata = {rdata_out[15:0], rsh[31:16]};
      3'h3: next_rdata = {rdata_out[7:0], rsh[31:8]};
      3'h4: next_rdata = rsh;
      default: next_rdata = rdata_out;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rdata_out <= '0;
    end else if (clk_en_in) begin
      if (state == DBSM_IDLE && req_in) begin
        rdata_out <= '0;
      end else if (state == DBSM_BUSY && acked && !write_out) begin
        rdata_out <= next_rdata;
      end
    end
  end

  a_prefetch_odd_err: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    clk_en_in && state == DBSM_IDLE && req_in && req_fetch_in && req_addr_in[0] |=> addr_err_out && !busy_out)
    else $error("Odd prefetch did not raise address error.");

  a_byte_lanes_copy: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    clk_en_in && busy_out && size == DBSM_SIZE_BYTE |=> bus_wdata_out == {4{$past(opnd[7:0])}})
    else $error("Byte write lanes wrong.");

  a_long_aligned_lanes: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    clk_en_in && busy_out && size == DBSM_SIZE_LONG && addr_out[1:0] == 2'h0 |=> bus_wdata_out == $past(opnd))
    else $error("Aligned long write lanes wrong.");

  a_word_port_second: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    clk_en_in && state == DBSM_BUSY && size == DBSM_SIZE_LONG && addr_out[1:0] == 2'h0 &&
    port_ack_hi_in && !port_ack_lo_in
    |=> size == DBSM_SIZE_WORD && addr_out[1:0] == 2'h2 && cycle_out)
    else $error("Long to word port did not continue with word at offset two.");

  a_odd_long_three: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    clk_en_in && state == DBSM_BUSY && size == DBSM_SIZE_LONG && addr_out[1:0] == 2'h3 &&
    port_ack_hi_in && port_ack_lo_in
    |=> size == DBSM_SIZE_THREE && addr_out[1:0] == 2'h0)
    else $error("Long at offset three did not continue as three bytes.");

  a_byte_port_step: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    clk_en_in && state == DBSM_BUSY && size == DBSM_SIZE_WORD && !port_ack_hi_in && port_ack_lo_in
    |=> size == DBSM_SIZE_BYTE && addr_out == $past(addr_out) + 32'h1)
    else $error("Word to byte port did not step to one byte.");

  a_wait_holds: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    state == DBSM_BUSY && !port_ack_hi_in && !port_ack_lo_in |=> $stable(addr_out) && $stable(size) && cycle_out)
    else $error("Cycle changed while waiting.");

  a_final_done: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    clk_en_in && state == DBSM_BUSY && acked && moved == left ##1 clk_en_in |=> done_out && !busy_out)
    else $error("Finished operand did not signal done.");

  a_word_lanes_even: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    clk_en_in && busy_out && size == DBSM_SIZE_WORD && !addr_out[0] |=> bus_wdata_out == {2{$past(opnd[15:0])}})
    else $error("Even word write lanes wrong.");

  a_word_lanes_odd: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    clk_en_in && busy_out && size == DBSM_SIZE_WORD && addr_out[0]
    |=> bus_wdata_out == {$past(opnd[15:8]), $past(opnd[15:8]), $past(opnd[7:0]), $past(opnd[15:8])})
    else $error("Odd word write lanes wrong.");

  a_three_lanes_half: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    clk_en_in && busy_out && size == DBSM_SIZE_THREE && addr_out[1:0] == 2'h2
    |=> bus_wdata_out == {2{$past(opnd[23:8])}})
    else $error("Three-byte write lanes at offset two wrong.");

  a_long_lanes_half: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    clk_en_in && busy_out && size == DBSM_SIZE_LONG && addr_out[1:0] == 2'h2
    |=> bus_wdata_out == {2{$past(opnd[31:16])}})
    else $error("Long write lanes at offset two wrong.");

  a_odd_word_split: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    clk_en_in && state == DBSM_BUSY && size == DBSM_SIZE_WORD && addr_out[0] && port_ack_hi_in && !port_ack_lo_in
    |=> size == DBSM_SIZE_BYTE && addr_out == $past(addr_out) + 32'h1 && cycle_out)
    else $error("Odd word to word port did not split into two bytes.");

  a_long_odd_word: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    clk_en_in && state == DBSM_BUSY && size == DBSM_SIZE_LONG && addr_out[1:0] == 2'h1 &&
    port_ack_hi_in && !port_ack_lo_in
    |=> size == DBSM_SIZE_THREE && addr_out[1:0] == 2'h2 && cycle_out)
    else $error("Odd long to word port did not continue as three bytes.");

  a_data_accepted: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    clk_en_in && state == DBSM_IDLE && req_in && !req_fetch_in |=> busy_out && cycle_out && !addr_err_out)
    else $error("Data operand was not accepted.");

  a_done_pulse: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    clk_en_in && done_out |=> !done_out)
    else $error("Done stood longer than one cycle.");
endmodule : dbsm_sequencer

// >>> dbsm_slave_model.sv
// Behavioural slave port of 8, 16 or 32 bits with a small byte memory.
`timescale 1ns/10ps
module dbsm_slave_model
  import dbsm_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        srst_in,
  input  wire logic [1:0]  port_in,
  input  wire logic [1:0]  wait_in,
  input  wire logic        cycle_in,
  input  wire logic        write_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [1:0]  size_in,
  input  wire logic [31:0] wdata_in,
  output logic             ack_hi_out,
  output logic             ack_lo_out,
  output logic [31:0]      rdata_out
);
  logic [7:0] mem [16];
  logic [1:0] cnt;
  logic [7:0] junk;
  logic [2:0] left, room, n, top;
  always_comb begin
    left = (size_in == DBSM_SIZE_LONG) ? 3'h4 : {1'b0, size_in};
    room = (port_in == 2'h3) ? 3'h4 - {1'b0, addr_in[1:0]} : (port_in == 2'h2) ? 3'h2 - {2'h0, addr_in[0]} : 3'h1;
    n    = (room < left) ? room : left;
    top  = (port_in == 2'h3) ? 3'h3 - {1'b0, addr_in[1:0]} :
           (port_in == 2'h2) ? 3'h3 - {2'h0, addr_in[0]} : 3'h3;
  end
  always_ff @(posedge clk_sys_in) begin
    junk <= srst_in ? 8'h0 : junk + 8'h5B;
    if (srst_in) begin
      {ack_hi_out, ack_lo_out} <= 2'h0;
      cnt <= 2'h0;
      rdata_out <= 32'h0;
    end else if (ack_hi_out || ack_lo_out || !cycle_in) begin
      // Ack lasts one cycle and released lanes keep changing, so stale data can never pass.
      {ack_hi_out, ack_lo_out} <= 2'h0;
      cnt <= 2'h0;
      rdata_out <= {4{junk}};
    end else if (cnt != wait_in) begin
      cnt <= cnt + 2'h1;
      rdata_out <= {4{junk}};
    end else begin
      {ack_hi_out, ack_lo_out} <= port_in;
      rdata_out <= ~{4{junk}};
      for (int j = 0; j < 4; j++) begin
        if (j < n) begin
          if (write_in) mem[addr_in[3:0] + j[3:0]] <= wdata_in[8*(top-j) +: 8];
          else rdata_out[8*(top-j) +: 8] <= mem[addr_in[3:0] + j[3:0]];
        end
      end
    end
  end
endmodule : dbsm_slave_model

// >>> test_dynamic_bus_sizing_mux.sv
// Self-checking bench for the dynamic bus sizing sequencer.
`timescale 1ns/10ps
module test_dynamic_bus_sizing_mux;
  import dbsm_pkg::*;
  logic        clk_sys_in, srst_in, req_in, req_write_in, req_fetch_in, ahi, alo;
  logic        busy, cyc, wr, sm, sl, done, aerr, err_seen, cen;
  logic [1:0]  req_size_in, port, wt;
  logic [31:0] req_addr_in, req_wdata_in, rd, addr, wdat, brd;
  logic [23:0] seq;
  int          n_errors, checks_done, ncyc, ticks;
  logic [15:0] pat [16] = '{16'h0123, 16'h0012, 16'h0101, 16'h0010, 16'h3333, 16'h3333, 16'h3333, 16'h3333,
                            16'h2323, 16'h2232, 16'h2323, 16'h2232, 16'h1230, 16'h1123, 16'h1212, 16'h1121};

  dbsm_sequencer dbsm_sequencer_inst (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .clk_en_in(cen),
    .req_in(req_in), .req_write_in(req_write_in), .req_fetch_in(req_fetch_in), .req_size_in(req_size_in),
    .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in), .port_ack_hi_in(ahi), .port_ack_lo_in(alo),
    .bus_rdata_in(brd), .busy_out(busy), .cycle_out(cyc), .write_out(wr), .addr_out(addr),
    .xfer_size_msb_out(sm), .xfer_size_lsb_out(sl), .bus_wdata_out(wdat), .done_out(done),
    .rdata_out(rd), .addr_err_out(aerr));
  dbsm_slave_model dbsm_slave_model_inst (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .port_in(port),
    .wait_in(wt), .cycle_in(cyc), .write_in(wr), .addr_in(addr), .size_in({sm, sl}), .wdata_in(wdat),
    .ack_hi_out(ahi), .ack_lo_out(alo), .rdata_out(brd));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // Lanes are judged at every acknowledged write cycle against the original operand.
  always @(posedge clk_sys_in) begin
    ticks++;
    if (ticks > 4000) begin
      n_errors++;
      conclude();
    end
    if (cyc && (ahi || alo)) begin
      seq = {seq[17:0], sm, sl, addr[3:0]};
      ncyc++;
      if (wr) for (int k = 0; k < 4; k++) chk("lane", req_wdata_in[8*(3-pat[{sm, sl, addr[1:0]}][4*k +: 4]) +: 8],
        wdat[8*k +: 8]);
    end
  end

  task automatic op(input logic w, f, input logic [1:0] s, p, input logic [31:0] a, d);
    int i;
    @(posedge clk_sys_in);
    {req_in, req_write_in, req_fetch_in, req_size_in, port} <= {1'b1, w, f, s, p};
    {req_addr_in, req_wdata_in} <= {a, d};
    {seq, ncyc, err_seen, i} = '0;
    @(posedge clk_sys_in);
    req_in <= 1'b0;
    do @(posedge clk_sys_in); while (done !== 1'b1 && aerr !== 1'b1 && ++i < 80);
    err_seen = (aerr === 1'b1);
  endtask : op

  task automatic t_mux();
    logic [2:0] c;
    for (int i = 0; i < 16; i++) begin
      c = (i[3:2] == 0) ? 3'h4 : {1'b0, i[3:2]};
      op(1'b1, 1'b0, i[3:2], 2'h3, 32'h8 + i[1:0], 32'hA1B2C3D4 ^ i);
      chk("cycles32", ({1'b0, i[1:0]} + c > 4) ? 2 : 1, ncyc);
      chk("no_err", 0, err_seen);
      op(1'b0, 1'b0, i[3:2], 2'h1, 32'h8 + i[1:0], 32'h0);
      chk("cycles8", c, ncyc);
      chk("rdata8", (32'hA1B2C3D4 ^ i) & ~(32'hFFFFFFFF << (8*c)), rd);
    end
    $display("test mux done");
  endtask : t_mux

  task automatic t_seq();
    op(1'b1, 1'b0, 2'h0, 2'h2, 32'h0, 32'h11223344);
    chk("seq", {6'h00, 6'h22}, seq);
    op(1'b1, 1'b0, 2'h2, 2'h1, 32'h0, 32'h5566);
    chk("seq", {6'h20, 6'h11}, seq);
    op(1'b1, 1'b0, 2'h0, 2'h2, 32'h1, 32'h778899AA);
    chk("seq", {6'h01, 6'h32, 6'h14}, seq);
    wt <= 2'h3;
    op(1'b0, 1'b0, 2'h0, 2'h2, 32'h1, 32'h0);
    chk("rdata16", 32'h778899AA, rd);
    wt <= 2'h1;
    op(1'b0, 1'b0, 2'h0, 2'h3, 32'h1, 32'h0);
    chk("rdata32", 32'h778899AA, rd);
    op(1'b1, 1'b0, 2'h2, 2'h2, 32'h5, 32'hBEEF);
    chk("seq", {6'h25, 6'h16}, seq);
    op(1'b1, 1'b0, 2'h0, 2'h3, 32'h3, 32'h0F1E2D3C);
    chk("seq", {6'h03, 6'h34}, seq);
    $display("test seq done");
  endtask : t_seq

  task automatic t_fetch();
    op(1'b0, 1'b1, 2'h0, 2'h3, 32'h5, 32'h0);
    chk("fetch_err", 1, err_seen);
    chk("fetch_cyc", 0, ncyc);
    op(1'b0, 1'b1, 2'h0, 2'h3, 32'h4, 32'h0);
    chk("fetch_ok", 0, err_seen);
    chk("fetch_cyc", 1, ncyc);
    $display("test fetch done");
  endtask : t_fetch

  // A low clock enable must hold off a request and hold a pulse that is already out.
  task automatic t_hold();
    @(posedge clk_sys_in);
    {cen, req_in, req_write_in, req_fetch_in, req_size_in, port} <= {1'b0, 1'b1, 1'b0, 1'b1, 2'h0, 2'h3};
    req_addr_in <= 32'h5;
    repeat (3) @(posedge clk_sys_in);
    chk("hold_idle", 0, {busy, cyc, aerr});
    cen <= 1'b1;
    @(posedge clk_sys_in);
    {cen, req_in} <= 2'h0;
    repeat (2) @(posedge clk_sys_in);
    chk("hold_err", 1, aerr);
    cen <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    chk("hold_free", 0, aerr);
    $display("test hold done");
  endtask : t_hold

  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    {srst_in, cen, req_in, req_write_in, req_fetch_in, req_size_in, port, wt} = {2'h3, 5'h0, 2'h3, 2'h1};
    {req_addr_in, req_wdata_in, n_errors, checks_done, ticks, ncyc, seq} = '0;
    repeat (5) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    t_mux();
    t_seq();
    t_fetch();
    t_hold();
    conclude();
  end
endmodule : test_dynamic_bus_sizing_mux
